// ===== pic_core_model.sv
// Processor core model that completes instructions and follows vector loads
`timescale 1ns/1ns
module pic_core_model (
  input wire logic ref_clk,          // Clock
  input wire logic reset,            // Asynchronous reset, high
  input wire logic step,             // Bench asks for one instruction completion
  input wire logic service_busy,     // Controller sequence running
  input wire logic pc_load,          // Load strobe from the controller
  input wire logic [15:0] pc_value,  // Address to load
  output logic instr_done,           // Instruction completes
  output logic [15:0] return_pc,     // Address of the next instruction
  output logic [15:0] core_pc        // Program counter of the core
);
  // Completions only while no sequence runs, as a real core stalls then
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      instr_done <= 1'b0;
    end else begin
      instr_done <= step && !service_busy;
    end
  end

  // Counter follows loads, else advances once per completed instruction
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      core_pc <= 16'h0000;
    end else begin
      core_pc <= pc_load ? pc_value : core_pc + {15'h0000, instr_done};
    end
  end

  assign return_pc = core_pc + 16'h0001;
endmodule

// ===== pic_pkg.sv
// Constants, types and register map of the priority interrupt controller
package pic_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [2:0] ADDR_ENABLE_HIGH = 3'h0;  // irq_enable_high
  localparam logic [2:0] ADDR_ENABLE_LOW = 3'h1;   // irq_enable_low
  localparam logic [2:0] ADDR_REQUEST_HIGH = 3'h2; // irq_request_high
  localparam logic [2:0] ADDR_REQUEST_LOW = 3'h3;  // irq_request_low
  localparam logic [2:0] ADDR_EDGE_SELECT = 3'h4;  // ext_edge_select
  localparam logic [2:0] ADDR_STATUS_WORD = 3'h5;  // processor_status_word
  localparam logic [2:0] ADDR_STATE = 3'h6;        // Controller state, read only

  // ----------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [11:0] RST_SOURCES = 12'h000;
  localparam logic [3:0] RST_STACK_PTR = 4'hf;
  localparam int MASTER_ENABLE_BIT = 2;  // Master enable inside the status word
  localparam int WATCHDOG_SRC = 2;       // Watchdog bit in the 12-bit source vector
  localparam int EXT_A_SRC = 11;         // Highest priority source bit
  localparam int NUM_SOURCES = 12;
  localparam int NUM_PINS = 4;
  localparam int STACK_DEPTH = 16;

  // ----------------------------------------------------------------
  // Vectors and timing
  // ----------------------------------------------------------------
  localparam logic [15:0] VEC_RESET = 16'hfffe;
  localparam logic [15:0] VEC_TOP = 16'hfffa;   // Level 1 vector
  localparam logic [15:0] VEC_STEP = 16'h0002;  // Spacing between levels
  localparam int TIMER_C_LEVEL = 7;             // Level whose vector is a parameter
  localparam int ACCEPT_PERIODS = 8;            // Oscillator periods per acceptance
  localparam int OSC_PER_CLK = 1;               // ref_clk runs at the oscillator rate
  localparam int ACCEPT_CYCLES = ACCEPT_PERIODS / OSC_PER_CLK;
  localparam logic [2:0] ACCEPT_LAST = 3'(ACCEPT_CYCLES - 1);
  localparam logic [2:0] PUSH_LAST = 3'h2;      // Three stack bytes
  localparam logic [3:0] PUSH_COUNT = 4'h3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_BOOT, ST_IDLE, ST_ACCEPT, ST_RETURN} pic_state_t;

  typedef struct packed {
    logic [3:0] timer_match;      // Timer a..d compare matches, a in bit 3
    logic conversion_done;        // Converter finished
    logic watchdog_match;         // Watchdog counter match
    logic interval_overflow;      // Interval timer overflow
    logic serial_done;            // Serial transfer finished
  } pic_events_t;

endpackage

// ===== pic_top.sv
// Priority interrupt controller: flags, enables, priority and acceptance sequence
// What this block does
// - External pins latch falling, rising or both edges
// - Timer compare matches set timer flags
// - Conversion finish sets converter flag
// - Watchdog flag interrupts only when reset-select clear
// - Interval timer overflow sets its flag
// - Accept needs flag, enable and master enable
// - Reset and break ignore all gating
// - Disabled source is never accepted
// - Fixed priority, one vector per source
// - Request pends until accepted or cleared
// - Acceptance after instruction, eight oscillator periods
// - Acceptance clears master enable
// - After break, further maskable interrupts blocked
// - Acceptance clears the accepted request flag
// - Push return address and status, three decrements
// - Load vector into program counter
// - Only program counter and status saved
// - Request flags readable and writable
// - Master enable clear blocks every request
// - Enable op sets master enable for nesting
// - Return op ends the service routine
// - Simultaneous requests settled by fixed order
// - Pin edges latched, polled next cycle
`timescale 1ns/1ns

module pic_top #(
  parameter logic [15:0] TIMER_C_VECTOR = 16'hffef,
  parameter logic [15:0] BREAK_VECTOR = 16'hffde
) (
  input wire logic ref_clk,                       // Controller clock
  input wire logic reset,                         // Asynchronous reset, high
  input wire logic [2:0] reg_addr,                // Register address
  input wire logic [7:0] reg_wdata,               // Register write data
  input wire logic reg_wr,                        // Write strobe
  input wire logic reg_rd,                        // Read strobe
  output logic [7:0] reg_rdata,                   // Read data, cycle after strobe
  input wire logic ext_request_pin_a,             // External request pin a
  input wire logic ext_request_pin_b,             // External request pin b
  input wire logic ext_request_pin_c,             // External request pin c
  input wire logic ext_request_pin_d,             // External request pin d
  input wire pic_pkg::pic_events_t events,        // Peripheral event pulses
  input wire logic watchdog_reset_select,         // Watchdog acts as reset when high
  input wire logic instr_done,                    // Current instruction completes
  input wire logic [15:0] return_pc,              // Return address at completion
  input wire logic enable_irqs_op,                // Enable instruction executed
  input wire logic return_from_service_op,        // Return instruction executed
  input wire logic software_break_op,             // Break instruction executed
  output logic service_busy,                      // Acceptance or return in progress
  output logic pc_load,                           // Load pc_value into the core
  output logic [15:0] pc_value,                   // Vector or restored address
  output logic [7:0] processor_status_word,       // Status word
  output logic [3:0] stack_ptr                    // Stack pointer
);

  // ----------------------------------------------------------------
  // State and storage
  // ----------------------------------------------------------------
  pic_pkg::pic_state_t state_reg;
  logic [2:0] cnt_reg;
  logic [7:0] en_high_reg;
  logic [3:0] en_low_reg;
  logic [11:0] req_reg;
  logic [11:0] req_next;
  logic [7:0] edge_sel_reg;
  logic [7:0] psw_reg;
  logic [7:0] saved_psw_reg;
  logic [15:0] ret_pc_reg;
  logic [7:0] pop_lo_reg;
  logic [3:0] sp_reg;
  logic nmi_block_reg;
  logic pc_load_reg;
  logic [15:0] pc_value_reg;
  logic [7:0] rdata_reg;
  logic [7:0] stack_mem [pic_pkg::STACK_DEPTH];
  logic [3:0] pin_s1_reg;
  logic [3:0] pin_s2_reg;
  logic [3:0] pin_s3_reg;
  logic [3:0] pin_edge;
  logic [11:0] set_ev;
  logic [11:0] ready;
  logic [11:0] grant;
  logic [3:0] grant_idx;
  logic any_ready;
  logic accept_start;
  logic brk_start;
  logic [15:0] grant_vec;
  logic [7:0] push_byte;
  logic [7:0] pop_byte;
  logic [3:0] pop_addr;
  logic [3:0] level;

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  // Three flip-flops per pin; edges judged from the second and third
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pin_s1_reg <= 4'h0;
      pin_s2_reg <= 4'h0;
      pin_s3_reg <= 4'h0;
    end else begin
      pin_s1_reg <= {ext_request_pin_d, ext_request_pin_c, ext_request_pin_b,
                     ext_request_pin_a};
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
    end
  end

  // Two select bits per pin: bit 1 rising, bit 0 falling, both for either
  always_comb begin
    pin_edge = 4'h0;
    for (int i = 0; i < pic_pkg::NUM_PINS; i++) begin
      pin_edge[i] = (edge_sel_reg[2*i+1] & pin_s2_reg[i] & ~pin_s3_reg[i]) |
                    (edge_sel_reg[2*i] & ~pin_s2_reg[i] & pin_s3_reg[i]);
    end
  end

  // Source events in priority order, bit 11 is level 1
  assign set_ev = {pin_edge[0], pin_edge[1], events.timer_match[3],
                   events.timer_match[2], pin_edge[2], pin_edge[3],
                   events.timer_match[1], events.timer_match[0],
                   events.conversion_done,
                   events.watchdog_match,
                   events.interval_overflow,
                   events.serial_done};

  // ----------------------------------------------------------------
  // Priority resolution
  // ----------------------------------------------------------------
  // Gate by flag, individual enable and master enable
  always_comb begin
    ready = req_reg & {en_high_reg, en_low_reg} &
            {pic_pkg::NUM_SOURCES{psw_reg[pic_pkg::MASTER_ENABLE_BIT]}};
    if (watchdog_reset_select) begin
      ready[pic_pkg::WATCHDOG_SRC] = 1'b0;
    end
  end

  // Highest set bit wins; fixed order settles ties
  always_comb begin
    grant = 12'h000;
    grant_idx = 4'h0;
    for (int i = 0; i < pic_pkg::NUM_SOURCES; i++) begin
      if (ready[i]) begin
        grant = 12'h000;
        grant[i] = 1'b1;
        grant_idx = 4'(i);
      end
    end
  end

  assign any_ready = |ready;
  assign level = 4'(pic_pkg::EXT_A_SRC + 1) - grant_idx;

  // Vector per level, with the timer c slot supplied by parameter
  always_comb begin
    if (level == 4'(pic_pkg::TIMER_C_LEVEL)) begin
      grant_vec = TIMER_C_VECTOR;
    end else if (level > 4'(pic_pkg::TIMER_C_LEVEL)) begin
      grant_vec = pic_pkg::VEC_TOP - pic_pkg::VEC_STEP * 16'(level - 4'h2);
    end else begin
      grant_vec = pic_pkg::VEC_TOP - pic_pkg::VEC_STEP * 16'(level - 4'h1);
    end
  end

  // Break is taken whenever the controller is idle; maskable only at completion, unblocked
  assign brk_start = (state_reg == pic_pkg::ST_IDLE) & software_break_op;
  assign accept_start = brk_start | ((state_reg == pic_pkg::ST_IDLE) & instr_done &
                        any_ready & ~nmi_block_reg);

  // ----------------------------------------------------------------
  // Request flags
  // ----------------------------------------------------------------
  // Events win over software writes and over acceptance clears
  always_comb begin
    req_next = req_reg;
    if (reg_wr && reg_addr == pic_pkg::ADDR_REQUEST_HIGH) begin
      req_next[11:4] = reg_wdata;
    end
    if (reg_wr && reg_addr == pic_pkg::ADDR_REQUEST_LOW) begin
      req_next[3:0] = reg_wdata[7:4];
    end
    if (accept_start && !brk_start) begin
      req_next = req_next & ~grant;
    end
    req_next = req_next | set_ev;
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      req_reg <= pic_pkg::RST_SOURCES;
    end else begin
      req_reg <= req_next;
    end
  end

  // ----------------------------------------------------------------
  // Enable and edge select registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      en_high_reg <= pic_pkg::RST_BYTE;
      en_low_reg <= 4'h0;
      edge_sel_reg <= pic_pkg::RST_BYTE;
    end else if (reg_wr) begin
      if (reg_addr == pic_pkg::ADDR_ENABLE_HIGH) begin
        en_high_reg <= reg_wdata;
      end
      if (reg_addr == pic_pkg::ADDR_ENABLE_LOW) begin
        en_low_reg <= reg_wdata[7:4];
      end
      if (reg_addr == pic_pkg::ADDR_EDGE_SELECT) begin
        edge_sel_reg <= reg_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Status word
  // ----------------------------------------------------------------
  // Write, enable op, acceptance clear, then return restore
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      psw_reg <= pic_pkg::RST_BYTE;
    end else begin
      if (reg_wr && reg_addr == pic_pkg::ADDR_STATUS_WORD) begin
        psw_reg <= reg_wdata;
      end
      if (enable_irqs_op) begin
        psw_reg[pic_pkg::MASTER_ENABLE_BIT] <= 1'b1;
      end
      if (accept_start) begin
        psw_reg[pic_pkg::MASTER_ENABLE_BIT] <= 1'b0;
      end
      if (state_reg == pic_pkg::ST_RETURN && cnt_reg == 3'h0) begin
        psw_reg <= pop_byte;
      end
    end
  end

  localparam logic [2:0] PUSH_LAST_L = pic_pkg::PUSH_LAST;

  // Break blocks maskable acceptance until the routine returns
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      nmi_block_reg <= 1'b0;
    end else if (brk_start) begin
      nmi_block_reg <= 1'b1;
    end else if (state_reg == pic_pkg::ST_RETURN && cnt_reg == PUSH_LAST_L) begin
      nmi_block_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Boot loads the reset vector; accept and return walk their bytes
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_reg <= pic_pkg::ST_BOOT;
      cnt_reg <= 3'h0;
    end else begin
      unique case (state_reg)
        pic_pkg::ST_BOOT: begin
          state_reg <= pic_pkg::ST_IDLE;
        end
        pic_pkg::ST_IDLE: begin
          cnt_reg <= 3'h0;
          if (accept_start) begin
            state_reg <= pic_pkg::ST_ACCEPT;
          end else if (return_from_service_op) begin
            state_reg <= pic_pkg::ST_RETURN;
          end
        end
        pic_pkg::ST_ACCEPT: begin
          cnt_reg <= cnt_reg + 3'h1;
          if (cnt_reg == pic_pkg::ACCEPT_LAST) begin
            state_reg <= pic_pkg::ST_IDLE;
          end
        end
        pic_pkg::ST_RETURN: begin
          cnt_reg <= cnt_reg + 3'h1;
          if (cnt_reg == PUSH_LAST_L) begin
            state_reg <= pic_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // Capture return address, prior status word and vector at acceptance
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ret_pc_reg <= 16'h0000;
      saved_psw_reg <= pic_pkg::RST_BYTE;
      pc_value_reg <= 16'h0000;
      pop_lo_reg <= pic_pkg::RST_BYTE;
    end else begin
      if (accept_start) begin
        ret_pc_reg <= return_pc;
        saved_psw_reg <= psw_reg;
        pc_value_reg <= brk_start ? BREAK_VECTOR : grant_vec;
      end
      if (state_reg == pic_pkg::ST_BOOT) begin
        pc_value_reg <= pic_pkg::VEC_RESET;
      end
      if (state_reg == pic_pkg::ST_RETURN && cnt_reg == 3'h1) begin
        pop_lo_reg <= pop_byte;
      end
      if (state_reg == pic_pkg::ST_RETURN && cnt_reg == PUSH_LAST_L) begin
        pc_value_reg <= {pop_byte, pop_lo_reg};
      end
    end
  end

  // Program counter load pulse after boot, acceptance end and return end
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pc_load_reg <= 1'b0;
    end else begin
      pc_load_reg <= (state_reg == pic_pkg::ST_BOOT) |
                     (state_reg == pic_pkg::ST_ACCEPT && cnt_reg == pic_pkg::ACCEPT_LAST) |
                     (state_reg == pic_pkg::ST_RETURN && cnt_reg == PUSH_LAST_L);
    end
  end

  // ----------------------------------------------------------------
  // Stack
  // ----------------------------------------------------------------
  // High address byte first, then low byte, then status word
  always_comb begin
    unique case (cnt_reg)
      3'h0: push_byte = ret_pc_reg[15:8];
      3'h1: push_byte = ret_pc_reg[7:0];
      default: push_byte = saved_psw_reg;
    endcase
  end

  assign pop_addr = sp_reg + 4'h1;
  assign pop_byte = stack_mem[pop_addr];

  // Stack bytes carry no reset; only the pointer does
  always_ff @(posedge ref_clk) begin
    if (state_reg == pic_pkg::ST_ACCEPT && cnt_reg <= PUSH_LAST_L) begin
      stack_mem[sp_reg] <= push_byte;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sp_reg <= pic_pkg::RST_STACK_PTR;
    end else if (state_reg == pic_pkg::ST_ACCEPT && cnt_reg <= PUSH_LAST_L) begin
      sp_reg <= sp_reg - 4'h1;
    end else if (state_reg == pic_pkg::ST_RETURN) begin
      sp_reg <= pop_addr;
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  // Data stand only in the cycle after the read strobe
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rdata_reg <= pic_pkg::RST_BYTE;
    end else if (reg_rd) begin
      unique case (reg_addr)
        pic_pkg::ADDR_ENABLE_HIGH: rdata_reg <= en_high_reg;
        pic_pkg::ADDR_ENABLE_LOW: rdata_reg <= {en_low_reg, 4'h0};
        pic_pkg::ADDR_REQUEST_HIGH: rdata_reg <= req_reg[11:4];
        pic_pkg::ADDR_REQUEST_LOW: rdata_reg <= {req_reg[3:0], 4'h0};
        pic_pkg::ADDR_EDGE_SELECT: rdata_reg <= edge_sel_reg;
        pic_pkg::ADDR_STATUS_WORD: rdata_reg <= psw_reg;
        pic_pkg::ADDR_STATE: rdata_reg <= {service_busy, nmi_block_reg, 2'h0, sp_reg};
        default: rdata_reg <= pic_pkg::RST_BYTE;
      endcase
    end else begin
      rdata_reg <= pic_pkg::RST_BYTE;
    end
  end

  // Outputs
  assign reg_rdata = rdata_reg;
  assign service_busy = (state_reg == pic_pkg::ST_ACCEPT) | (state_reg == pic_pkg::ST_RETURN);
  assign pc_load = pc_load_reg;
  assign pc_value = pc_value_reg;
  assign processor_status_word = psw_reg;
  assign stack_ptr = sp_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_accept_len: assert property (@(posedge ref_clk) disable iff (reset)
    accept_start |=> (state_reg == pic_pkg::ST_ACCEPT) [*8] ##1 pc_load_reg)
    else $error("acceptance did not take eight cycles");

  chk_ie_clear: assert property (@(posedge ref_clk) disable iff (reset)
    accept_start && !enable_irqs_op |=> !psw_reg[pic_pkg::MASTER_ENABLE_BIT])
    else $error("master enable not cleared at acceptance");

  chk_sp_three: assert property (@(posedge ref_clk) disable iff (reset)
    accept_start |-> ##4 (sp_reg == $past(sp_reg, 4) - 4'h3))
    else $error("stack pointer not lowered by three");

  chk_master_gate: assert property (@(posedge ref_clk) disable iff (reset)
    !psw_reg[pic_pkg::MASTER_ENABLE_BIT] && !software_break_op |-> !accept_start)
    else $error("accepted with master enable clear");

  chk_flag_clear: assert property (@(posedge ref_clk) disable iff (reset)
    accept_start && !brk_start && ((set_ev & grant) == 12'h000) |=>
    ((req_reg & $past(grant)) == 12'h000))
    else $error("accepted flag not cleared");

  chk_reset_vec: assert property (@(posedge ref_clk) disable iff (reset)
    state_reg == pic_pkg::ST_BOOT |=> pc_load_reg && pc_value_reg == pic_pkg::VEC_RESET)
    else $error("reset vector not loaded");

  chk_return_from_service_op_pop: assert property (@(posedge ref_clk) disable iff (reset)
    $rose(state_reg == pic_pkg::ST_RETURN) |-> ##3 pc_load_reg &&
    (sp_reg == $past(sp_reg, 3) + 4'h3))
    else $error("return did not pop three bytes");

  chk_edge_latch: assert property (@(posedge ref_clk) disable iff (reset)
    pin_edge[0] |=> req_reg[pic_pkg::EXT_A_SRC])
    else $error("pin edge not latched");

  chk_nmi_block: assert property (@(posedge ref_clk) disable iff (reset)
    nmi_block_reg && !software_break_op |-> !accept_start)
    else $error("accepted while blocked after break");

  chk_brk_ungated: assert property (@(posedge ref_clk) disable iff (reset)
    state_reg == pic_pkg::ST_IDLE && software_break_op |=> state_reg == pic_pkg::ST_ACCEPT)
    else $error("break not accepted");

endmodule

// ===== tb_top.sv
// Self-checking testbench for the priority interrupt controller
`timescale 1ns/1ns
module tb_top;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic ext_request_pin_a = 1'b0;
  logic ext_request_pin_b = 1'b0;
  logic ext_request_pin_c = 1'b0;
  logic ext_request_pin_d = 1'b0;
  logic watchdog_reset_select = 1'b0;
  pic_pkg::pic_events_t events = '0;
  logic step = 1'b0;
  logic enable_irqs_op = 1'b0;
  logic return_from_service_op = 1'b0;
  logic software_break_op = 1'b0;
  logic instr_done, service_busy, pc_load;
  logic [15:0] return_pc, pc_value, core_pc;
  logic [7:0] reg_rdata, processor_status_word;
  logic [3:0] stack_ptr;
  int fails = 0;
  int comparisons = 0;

  // Clock at 10 MHz
  always #50 ref_clk = ~ref_clk;

  pic_top pic_top_i (.ref_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .ext_request_pin_a, .ext_request_pin_b, .ext_request_pin_c, .ext_request_pin_d, .events,
    .watchdog_reset_select, .instr_done, .return_pc, .enable_irqs_op, .return_from_service_op,
    .software_break_op, .service_busy, .pc_load, .pc_value, .processor_status_word, .stack_ptr);
  pic_core_model pic_core_model_i (.ref_clk, .reset, .step, .service_busy, .pc_load, .pc_value,
    .instr_done, .return_pc, .core_pc);

  task automatic chk(input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("FAIL at %0t: expected %h got %h", $time, exp, got);
    end
  endtask

  // Register bus cycles and one-cycle operation pulses
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk({8'h00, exp}, {8'h00, reg_rdata});
  endtask
  task automatic op(input logic [3:0] w);
    @(posedge ref_clk);
    {step, enable_irqs_op, return_from_service_op, software_break_op} <= w;
    @(posedge ref_clk);
    {step, enable_irqs_op, return_from_service_op, software_break_op} <= 4'h0;
  endtask

  // Counts busy cycles up to the load strobe, then checks the loaded address
  task automatic run(input logic [15:0] vec, input int busy_exp);
    int busy;
    busy = 0;
    for (int i = 0; i < 14; i++) begin
      #1;
      if (pc_load === 1'b1) break;
      if (service_busy === 1'b1) busy++;
      @(posedge ref_clk);
    end
    chk(16'(busy), 16'(busy_exp));
    if (busy_exp != 0) chk(pc_value, vec);
  endtask

  task automatic t_reset();
    #1 chk({15'h0000, pc_load}, 16'h0001);
    chk(pc_value, pic_pkg::VEC_RESET);
    chk({12'h000, stack_ptr}, 16'h000f);
    $display("reset test done");
  endtask
  task automatic t_edge();
    wr(pic_pkg::ADDR_EDGE_SELECT, 8'h02);
    ext_request_pin_a <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rd(pic_pkg::ADDR_REQUEST_HIGH, 8'h80);
    wr(pic_pkg::ADDR_REQUEST_HIGH, 8'h00);
    ext_request_pin_a <= 1'b0;
    repeat (6) @(posedge ref_clk);
    rd(pic_pkg::ADDR_REQUEST_HIGH, 8'h00);
    rd(3'h7, 8'h00);
    $display("edge test done");
  endtask
  task automatic t_gate();
    wr(pic_pkg::ADDR_ENABLE_HIGH, 8'h00);
    wr(pic_pkg::ADDR_REQUEST_HIGH, 8'h80);
    op(4'h4);
    op(4'h8);
    run(16'h0000, 0);
    rd(pic_pkg::ADDR_REQUEST_HIGH, 8'h80);
    wr(pic_pkg::ADDR_ENABLE_HIGH, 8'h80);
    op(4'h8);
    run(pic_pkg::VEC_TOP, pic_pkg::ACCEPT_CYCLES);
    chk({12'h000, stack_ptr}, 16'h000c);
    chk({8'h00, processor_status_word}, 16'h0000);
    rd(pic_pkg::ADDR_REQUEST_HIGH, 8'h00);
    $display("gating test done");
  endtask
  task automatic t_nest();
    wr(pic_pkg::ADDR_ENABLE_HIGH, 8'hff);
    wr(pic_pkg::ADDR_ENABLE_LOW, 8'hff);
    rd(pic_pkg::ADDR_ENABLE_LOW, 8'hf0);
    @(posedge ref_clk);
    events <= pic_pkg::pic_events_t'(8'h88);
    @(posedge ref_clk);
    events <= '0;
    op(4'h8);
    run(16'h0000, 0);
    op(4'h4);
    op(4'h8);
    run(16'hfff6, pic_pkg::ACCEPT_CYCLES);
    rd(pic_pkg::ADDR_REQUEST_LOW, 8'h80);
    op(4'h2);
    run(16'hfffc, 3);
    chk({8'h00, processor_status_word}, 16'h0004);
    chk({12'h000, stack_ptr}, 16'h000c);
    $display("nesting test done");
  endtask
  task automatic t_break();
    wr(pic_pkg::ADDR_REQUEST_LOW, 8'h00);
    wr(pic_pkg::ADDR_STATUS_WORD, 8'h00);
    op(4'h1);
    run(16'hffde, pic_pkg::ACCEPT_CYCLES);
    wr(pic_pkg::ADDR_STATUS_WORD, 8'h04);
    wr(pic_pkg::ADDR_REQUEST_LOW, 8'h80);
    op(4'h8);
    run(16'h0000, 0);
    op(4'h2);
    run(16'hfffd, 3);
    $display("break test done");
  endtask
  // Watchdog flag is held off while it selects reset, accepted once cleared
  task automatic t_wdog();
    wr(pic_pkg::ADDR_REQUEST_LOW, 8'h00);
    wr(pic_pkg::ADDR_STATUS_WORD, 8'h04);
    @(posedge ref_clk);
    watchdog_reset_select <= 1'b1;
    events <= pic_pkg::pic_events_t'(8'h04);
    @(posedge ref_clk);
    events <= '0;
    op(4'h8);
    run(16'h0000, 0);
    rd(pic_pkg::ADDR_REQUEST_LOW, 8'h40);
    @(posedge ref_clk);
    watchdog_reset_select <= 1'b0;
    op(4'h8);
    run(16'hffea, pic_pkg::ACCEPT_CYCLES);
    $display("watchdog test done");
  endtask

  task automatic end_of_test();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Main sequence after two reset cycles
  initial begin
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    t_reset();
    t_edge();
    t_gate();
    t_nest();
    t_break();
    t_wdog();
    end_of_test();
  end

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #200000;
    fails++;
    end_of_test();
  end
endmodule
